// ---- test/ext_osc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_osc_model (
    input wire logic clk_sys_in,
    input wire logic run_in,
    output logic clk_out
);
    logic [1:0] div_q = 2'h0;

    // source toggles every four cycles; a dead source freezes its level
    initial clk_out = 1'b1;
    always @(posedge clk_sys_in) begin
        if (run_in) begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) begin
                clk_out <= ~clk_out;
            end
        end
    end
endmodule : ext_osc_model
`default_nettype wire

// ---- test/fail_safe_clock_monitor_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fail_safe_clock_monitor_props (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [7:0] oscillator_config_byte_in,
    input wire logic power_managed_entry_in,
    input wire logic watchdog_enable_in,
    input wire logic [clock_monitor_pkg::ADDR_W-1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic irq_out,
    input wire logic internal_clk_select_out,
    input wire logic [clock_monitor_pkg::FREQ_SEL_W-1:0] backup_freq_out,
    input wire logic [clock_monitor_pkg::TUNE_W-1:0] rc_tune_out,
    input wire logic rc_run_out,
    input wire logic watchdog_reset_out
);
    import clock_monitor_pkg::*;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    // monitor enable bit, and register writes that may legally move the interrupt line
    wire logic en = oscillator_config_byte_in[MONITOR_ENABLE_BIT];
    wire logic mwr = wr_strobe_in && addr_in == MASK_OFFSET;
    wire logic fwr = wr_strobe_in && addr_in == FLAG_OFFSET;

    a_wd_one_cycle: assert property (watchdog_reset_out |=> !watchdog_reset_out)
        else $error("watchdog reset longer than one cycle");
    a_fail_internal: assert property (watchdog_reset_out |-> internal_clk_select_out)
        else $error("failure without internal clock select");
    a_failsafe_holds: assert property (
        watchdog_reset_out ##1 !power_managed_entry_in [*8] |-> internal_clk_select_out)
        else $error("fail-safe left without exit event");
    a_fail_needs_en: assert property (watchdog_reset_out |-> $past(en, 2))
        else $error("failure while monitor disabled");
    a_irq_rise_cause: assert property (
        $rose(irq_out) |-> watchdog_reset_out || $past(mwr) || $past(mwr, 2))
        else $error("irq rose without failure or mask write");
    a_irq_fall_cause: assert property (
        $fell(irq_out) |-> $past(fwr) || $past(fwr, 2) || $past(mwr) || $past(mwr, 2))
        else $error("irq fell without flag or mask write");
    a_tune_write: assert property (
        wr_strobe_in && addr_in == TUNE_OFFSET |=> rc_tune_out == $past(wr_data_in[5:0]))
        else $error("tune output not updated by write");
    a_freq_write: assert property (
        wr_strobe_in && addr_in == CONTROL_OFFSET |=> backup_freq_out == $past(wr_data_in[6:4]))
        else $error("backup frequency not updated by write");
    a_run_request: assert property (
        !$past(reset_in) |-> rc_run_out == ($past(en) | $past(watchdog_enable_in)))
        else $error("rc run request wrong");

    c_failure: cover property (watchdog_reset_out);
    c_irq_clear: cover property ($fell(irq_out));
    c_exit: cover property (power_managed_entry_in ##[1:20] !internal_clk_select_out);
endmodule : fail_safe_clock_monitor_props

bind fail_safe_clock_monitor fail_safe_clock_monitor_props i_props (.*);
`default_nettype wire

// ---- test/fail_safe_clock_monitor_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fail_safe_clock_monitor_tb_top;
    import clock_monitor_pkg::*;
    logic clk_sys_in = 0, reset_in = 1, rc = 0, prdy = 0, pme = 0, wde = 0;
    logic wr = 0, rd = 0, osc_run = 0, wclk, irq, isel, rcrun, wdr;
    logic [7:0] cfg = 8'h40, wdat = 8'h00, rdo;
    logic [4:0] addr = 5'h00;
    logic [2:0] bfreq;
    logic [5:0] tune;
    int fail_count = 0, n_tests = 0, wd_cnt = 0;

    initial forever #5 clk_sys_in = ~clk_sys_in;
    // rc stand-in gives one rising edge every two cycles
    always @(posedge clk_sys_in) rc <= ~rc;
    always @(posedge clk_sys_in) if (wdr === 1'b1) wd_cnt++;

    fail_safe_clock_monitor i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .clk_en_in(1'b1), .oscillator_config_byte_in(cfg), .watched_clk_in(wclk),
        .rc_osc_in(rc), .primary_ready_in(prdy), .power_managed_entry_in(pme),
        .watchdog_enable_in(wde), .addr_in(addr), .wr_data_in(wdat), .wr_strobe_in(wr),
        .rd_strobe_in(rd), .rd_data_out(rdo), .irq_out(irq), .internal_clk_select_out(isel),
        .backup_freq_out(bfreq), .rc_tune_out(tune), .rc_run_out(rcrun),
        .watchdog_reset_out(wdr));
    ext_osc_model i_osc (.clk_sys_in(clk_sys_in), .run_in(osc_run), .clk_out(wclk));

    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : tick

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr <= 1'b1;
        addr <= a;
        wdat <= d;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask : wreg

    // read data stand only in the cycle after the strobe
    task automatic creg(input string nm, input logic [4:0] a, input logic [7:0] e,
                        input logic [7:0] m = 8'hFF);
        @(posedge clk_sys_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 chk(nm, e, rdo & m);
    endtask : creg

    task automatic wait_fail();
        int c0;
        c0 = wd_cnt;
        for (int i = 0; i < 400 && wd_cnt == c0; i++) tick(1);
        if (wd_cnt == c0) begin
            fail_count++;
            $display("MISMATCH watchdog_reset exp 1 got 0");
            end_of_test();
        end
        tick(2);
    endtask : wait_fail

    task automatic do_reset();
        @(posedge clk_sys_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        tick(1);
    endtask : do_reset

    task automatic t_reset();
        do_reset();
        chk("internal_sel", 8'h01, {7'h0, isel});
        chk("rc_run", 8'h01, {7'h0, rcrun});
        creg("flag", FLAG_OFFSET, FLAG_RESET);
        creg("mask", MASK_OFFSET, MASK_RESET);
        creg("control", CONTROL_OFFSET, CONTROL_RESET);
        creg("tune", TUNE_OFFSET, {2'h0, TUNE_RESET});
        wreg(MASK_OFFSET, 8'h80);
        wreg(CONTROL_OFFSET, 8'h50);
        wreg(TUNE_OFFSET, 8'h2A);
        wreg(5'h14, 8'hFF);
        creg("control", CONTROL_OFFSET, 8'h50);
        creg("tune", TUNE_OFFSET, 8'h2A);
        creg("unmapped", 5'h14, 8'h00);
        chk("backup_freq", 8'h05, {5'h0, bfreq});
        chk("rc_tune", 8'h2A, {2'h0, tune});
        $display("t_reset done");
    endtask : t_reset

    // a watched clock with no falling edge never leaves the latch set
    task automatic t_quiet();
        @(posedge clk_sys_in);
        prdy <= 1'b1;
        tick(400);
        chk("wd_pulses", 8'h00, 8'(wd_cnt));
        chk("internal_sel", 8'h00, {7'h0, isel});
        creg("status", STATUS_OFFSET, 8'h04, 8'h05);
        $display("t_quiet done");
    endtask : t_quiet

    task automatic t_fail();
        @(posedge clk_sys_in);
        osc_run <= 1'b1;
        wait_fail();
        chk("internal_sel", 8'h01, {7'h0, isel});
        chk("irq", 8'h01, {7'h0, irq});
        creg("flag", FLAG_OFFSET, 8'h80);
        creg("control", CONTROL_OFFSET, 8'h50);
        creg("status", STATUS_OFFSET, 8'h01, 8'h01);
        osc_run <= 1'b0;
        tick(60);
        chk("internal_sel", 8'h01, {7'h0, isel});
        $display("t_fail done");
    endtask : t_fail

    task automatic t_recover();
        wreg(FLAG_OFFSET, 8'h80);
        creg("flag", FLAG_OFFSET, 8'h80);
        wreg(FLAG_OFFSET, 8'h00);
        creg("flag", FLAG_OFFSET, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        // secondary source this time, so both watched codes see a failure
        wreg(CONTROL_OFFSET, 8'h61);
        @(posedge clk_sys_in);
        pme <= 1'b1;
        @(posedge clk_sys_in);
        pme <= 1'b0;
        tick(10);
        chk("internal_sel", 8'h00, {7'h0, isel});
        chk("backup_freq", 8'h06, {5'h0, bfreq});
        osc_run <= 1'b1;
        wait_fail();
        creg("flag", FLAG_OFFSET, 8'h80);
        creg("control", CONTROL_OFFSET, 8'h61);
        osc_run <= 1'b0;
        $display("t_recover done");
    endtask : t_recover

    // running clock that must not be judged
    task automatic t_ignored(input logic [7:0] c, input logic [7:0] sel);
        int c0;
        do_reset();
        @(posedge clk_sys_in);
        cfg <= c;
        wreg(CONTROL_OFFSET, sel);
        c0 = wd_cnt;
        osc_run <= 1'b1;
        tick(400);
        osc_run <= 1'b0;
        chk("wd_pulses", 8'h00, 8'(wd_cnt - c0));
        $display("t_ignored done");
    endtask : t_ignored

    initial begin
        t_reset();
        t_quiet();
        t_fail();
        t_recover();
        t_ignored(8'h40, 8'h02);
        t_ignored(8'h40, 8'h03);
        t_ignored(8'h00, 8'h00);
        chk("rc_run", 8'h00, {7'h0, rcrun});
        // watchdog alone must still request the rc oscillator
        @(posedge clk_sys_in);
        wde <= 1'b1;
        tick(2);
        chk("rc_run", 8'h01, {7'h0, rcrun});
        end_of_test();
    end

    initial begin
        #1000000;
        fail_count++;
        $display("MISMATCH run_time exp done got hang");
        end_of_test();
    end
endmodule : fail_safe_clock_monitor_tb_top
`default_nettype wire

// ---- verilog/clock_monitor_pkg.sv ----
package clock_monitor_pkg;
    // register map, byte addresses on the plain register port
    localparam int ADDR_W = 5;
    localparam logic [4:0] FLAG_OFFSET = 5'h00;
    localparam logic [4:0] MASK_OFFSET = 5'h04;
    localparam logic [4:0] CONTROL_OFFSET = 5'h08;
    localparam logic [4:0] TUNE_OFFSET = 5'h0C;
    localparam logic [4:0] STATUS_OFFSET = 5'h10;
    // field positions
    localparam int FAIL_FLAG_BIT = 7;
    localparam int MONITOR_ENABLE_BIT = 6;
    localparam int FREQ_SEL_LSB = 4;
    localparam int FREQ_SEL_W = 3;
    localparam int CLK_SEL_LSB = 0;
    localparam int CLK_SEL_W = 2;
    localparam int TUNE_W = 6;
    localparam int STAT_FAILSAFE_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_RUNNING_BIT = 2;
    // clock select codes; only external sources are watched
    localparam logic [1:0] CLK_SEL_PRIMARY = 2'h0;
    localparam logic [1:0] CLK_SEL_SECONDARY = 2'h1;
    localparam logic [1:0] CLK_SEL_INTERNAL = 2'h2;
    // reset values
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [5:0] TUNE_RESET = 6'h00;
    // sample clock is the rc oscillator divided by this
    localparam int SAMPLE_DIVIDE = 64;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_MONITOR = 2'b01,
        ST_FAILSAFE = 2'b10
    } mode_e;
endpackage : clock_monitor_pkg

// ---- verilog/edge_latch_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_latch_monitor (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic watched_clk_in,
    monitor_link_if.monitor link
);
    import clock_monitor_pkg::*;

    typedef struct packed {
        logic clk_prev;
        logic latch;
        logic fail;
    } mon_state_s;

    mon_state_s state_q;
    mon_state_s state_d;

    // a falling edge in the same cycle as a sample rise sets: never a false alarm
    always_comb begin
        state_d = state_q;
        state_d.fail = 1'b0;
        state_d.clk_prev = watched_clk_in;
        if (!link.watch_en) begin
            state_d.latch = 1'b0;
        end else begin
            if (link.sample_fall && state_q.latch) begin
                state_d.fail = 1'b1;
            end
            if (link.sample_rise) begin
                state_d.latch = 1'b0;
            end
            if (state_q.clk_prev && !watched_clk_in) begin
                state_d.latch = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    assign link.fail = state_q.fail;
    assign link.latch_state = state_q.latch;
endmodule : edge_latch_monitor
`default_nettype wire

// ---- verilog/fail_safe_clock_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - monitoring only when config bit six set
// - rc oscillator kept running while monitoring enabled
// - sample clock is rc divided by 64
// - latch set on clock fall, cleared sample rise
// - latch still set at sample fall means failure
// - failure sets oscillator fail flag bit seven
// - failure switches to internal, control register untouched
// - failure resets watchdog counter and postscaler
// - only primary or secondary sources are watched
// - rc tuning scales sample period equally
// - watchdog disable never stops monitor rc oscillator
// - backup frequency follows three bit select field
// - fail-safe ends on reset or power-managed entry
// - monitoring resumes after fail-safe is cleared
module fail_safe_clock_monitor (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [7:0] oscillator_config_byte_in,
    input wire logic watched_clk_in,
    input wire logic rc_osc_in,
    input wire logic primary_ready_in,
    input wire logic power_managed_entry_in,
    input wire logic watchdog_enable_in,
    input wire logic [clock_monitor_pkg::ADDR_W-1:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_strobe_in,
    input wire logic rd_strobe_in,
    output logic [7:0] rd_data_out,
    output logic irq_out,
    output logic internal_clk_select_out,
    output logic [clock_monitor_pkg::FREQ_SEL_W-1:0] backup_freq_out,
    output logic [clock_monitor_pkg::TUNE_W-1:0] rc_tune_out,
    output logic rc_run_out,
    output logic watchdog_reset_out
);
    import clock_monitor_pkg::*;

    typedef struct packed {
        mode_e mode;
        logic fail_flag;
        logic fail_mask;
        logic [7:0] control;
        logic [TUNE_W-1:0] tune;
        logic [7:0] rd_data;
        logic irq;
        logic internal_sel;
        logic rc_run;
        logic wd_reset;
    } top_state_s;

    top_state_s state_q;
    top_state_s state_d;

    monitor_link_if link ();

    logic monitor_enabled;
    logic external_selected;

    // the non-volatile enable bit gates watching and the sample divider
    assign monitor_enabled = oscillator_config_byte_in[MONITOR_ENABLE_BIT];

    // an internally clocked system has nothing to watch
    assign external_selected =
        (state_q.control[CLK_SEL_LSB +: CLK_SEL_W] == CLK_SEL_PRIMARY) ||
        (state_q.control[CLK_SEL_LSB +: CLK_SEL_W] == CLK_SEL_SECONDARY);

    // watching only in normal run, so fail-safe is not re-entered repeatedly
    assign link.watch_en = monitor_enabled && external_selected &&
                           (state_q.mode == ST_MONITOR);

    // divider is its own, separate from any watchdog divider
    sample_clock_divider #(
        .DIVIDE(SAMPLE_DIVIDE)
    ) u_divider (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .run_in(monitor_enabled),
        .rc_osc_in(rc_osc_in),
        .link(link.divider)
    );

    edge_latch_monitor u_monitor (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .watched_clk_in(watched_clk_in),
        .link(link.monitor)
    );

    function automatic logic [7:0] read_mux(input logic [ADDR_W-1:0] a, input top_state_s s,
                                            input logic latch);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            FLAG_OFFSET: r[FAIL_FLAG_BIT] = s.fail_flag;
            MASK_OFFSET: r[FAIL_FLAG_BIT] = s.fail_mask;
            CONTROL_OFFSET: r = s.control;
            TUNE_OFFSET: r[TUNE_W-1:0] = s.tune;
            STATUS_OFFSET: begin
                r[STAT_FAILSAFE_BIT] = (s.mode == ST_FAILSAFE);
                r[STAT_LATCH_BIT] = latch;
                r[STAT_RUNNING_BIT] = (s.mode == ST_MONITOR);
            end
            default: r = 8'h00;
        endcase
        return r;
    endfunction : read_mux

    // mode sequence, register writes, flag and outputs
    always_comb begin
        state_d = state_q;
        state_d.wd_reset = 1'b0;
        state_d.rd_data = 8'h00;

        // register writes
        if (wr_strobe_in) begin
            unique case (addr_in)
                FLAG_OFFSET: begin
                    if (!wr_data_in[FAIL_FLAG_BIT]) begin
                        state_d.fail_flag = 1'b0;
                    end
                end
                MASK_OFFSET: state_d.fail_mask = wr_data_in[FAIL_FLAG_BIT];
                CONTROL_OFFSET: state_d.control = wr_data_in;
                TUNE_OFFSET: state_d.tune = wr_data_in[TUNE_W-1:0];
                default: state_d.control = state_q.control;
            endcase
        end

        // read data stands only in the cycle after the strobe
        if (rd_strobe_in) begin
            state_d.rd_data = read_mux(addr_in, state_q, link.latch_state);
        end

        unique case (state_q.mode)
            ST_STARTUP: begin
                // internal block clocks the part until the primary is ready
                state_d.internal_sel = 1'b1;
                if (primary_ready_in || !external_selected) begin
                    state_d.mode = ST_MONITOR;
                    state_d.internal_sel = !external_selected;
                end
            end
            ST_MONITOR: begin
                state_d.internal_sel = !external_selected;
                if (link.fail) begin
                    state_d.mode = ST_FAILSAFE;
                    state_d.internal_sel = 1'b1;
                    state_d.wd_reset = 1'b1;
                end
            end
            ST_FAILSAFE: begin
                // control register is not rewritten: it keeps showing the old source
                state_d.internal_sel = 1'b1;
                if (power_managed_entry_in) begin
                    state_d.mode = ST_STARTUP;
                end
            end
            default: state_d.mode = ST_STARTUP;
        endcase

        // set wins over a same-cycle software clear
        if (link.fail) begin
            state_d.fail_flag = 1'b1;
        end

        // rc stays on for the monitor whatever the watchdog does
        state_d.rc_run = monitor_enabled || watchdog_enable_in;
        state_d.irq = state_d.fail_flag && state_d.fail_mask;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q.mode <= ST_STARTUP;
            state_q.fail_flag <= FLAG_RESET[FAIL_FLAG_BIT];
            state_q.fail_mask <= MASK_RESET[FAIL_FLAG_BIT];
            state_q.control <= CONTROL_RESET;
            state_q.tune <= TUNE_RESET;
            state_q.rd_data <= 8'h00;
            state_q.irq <= 1'b0;
            state_q.internal_sel <= 1'b1;
            state_q.rc_run <= 1'b1;
            state_q.wd_reset <= 1'b0;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    // all outputs straight from flops
    assign rd_data_out = state_q.rd_data;
    assign irq_out = state_q.irq;
    assign internal_clk_select_out = state_q.internal_sel;
    assign backup_freq_out = state_q.control[FREQ_SEL_LSB +: FREQ_SEL_W];
    assign rc_tune_out = state_q.tune;
    assign rc_run_out = state_q.rc_run;
    assign watchdog_reset_out = state_q.wd_reset;
endmodule : fail_safe_clock_monitor
`default_nettype wire

// ---- verilog/monitor_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface monitor_link_if;
    logic sample_rise;
    logic sample_fall;
    logic watch_en;
    logic fail;
    logic latch_state;

    modport divider (output sample_rise, output sample_fall);
    modport monitor (input sample_rise, input sample_fall, input watch_en,
                     output fail, output latch_state);
    modport top (input sample_rise, input sample_fall, output watch_en,
                 input fail, input latch_state);
endinterface : monitor_link_if
`default_nettype wire

// ---- verilog/sample_clock_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_clock_divider #(
    parameter int DIVIDE = clock_monitor_pkg::SAMPLE_DIVIDE
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic run_in,
    input wire logic rc_osc_in,
    monitor_link_if.divider link
);
    import clock_monitor_pkg::*;

    localparam int CW = $clog2(DIVIDE);

    typedef struct packed {
        logic rc_prev;
        logic [CW-1:0] count;
        logic rise;
        logic fall;
    } div_state_s;

    div_state_s state_q;
    div_state_s state_d;

    // counts real rc edges, so any tuning of the rc scales the sample period too
    always_comb begin
        state_d = state_q;
        state_d.rise = 1'b0;
        state_d.fall = 1'b0;
        state_d.rc_prev = rc_osc_in;
        if (!run_in) begin
            state_d.count = '0;
        end else if (rc_osc_in && !state_q.rc_prev) begin
            state_d.count = state_q.count + 1'b1;
            if (state_q.count == CW'(DIVIDE / 2 - 1)) begin
                state_d.rise = 1'b1;
            end
            if (state_q.count == CW'(DIVIDE - 1)) begin
                state_d.fall = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= '0;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    assign link.sample_rise = state_q.rise;
    assign link.sample_fall = state_q.fall;
endmodule : sample_clock_divider
`default_nettype wire
